// >>> rtl/mtlc_defines.vh
// Overview of operation
// - Sixteen-bit down counter starts after count value, source, then enable bit set.
// - Each clock-count timer underflow sets its irq flag; counting continues.
// - Clock-count timer bit 4 is a selectable LCD divider source.
// - Clearing enable stops the clock-count timer and reloads its initial value.
// - Clock-count timer runs in power down; its underflow wakes the system.
// - Four-bit LCD divider; lc_write loads counter and reload; counter unreadable.
// - LCD divider divides by n+1 and reloads from lc_reload on underflow.
// - LCD divider underflow halved in frequency gives the LCD clock.
// - Timer 2 control bit 3 selects PWM output on the counter pin.
// - External source counts chosen pin edge; port C driver forced off.
// - Underflow sets each flag; interrupt taken or skip clears it.
// - With sync enabled, valid external edge sets synchronizer gating timer 1 source.
// - Synchronizer holds until sync_enable clears, reset, or auto-stop underflow.
// - Timer1 control bit 3 enables auto-stop, only with synchronizer selected.
// - Timer 1 starts on first source rising edge; pin sampled on core clock rising edges, edge counted chosen by LC control bit 0.
// - LCD divider starts on rising edge after first source falling edge.
// - Disabling PWM auto-control keeps pin validity; timer 1 stop also holds it.
// - With PWM output selected on the pin, timer 2 halts only after high interval or on underflow.
`ifndef MTLC_DEFINES_VH
`define MTLC_DEFINES_VH
`define MTLC_T3_INIT      16'hffff
`define MTLC_T3_CNT_LSB   0
`define MTLC_T3_EN_BIT    2
`define MTLC_T3_SRC_BIT   3
`define MTLC_T3_LC_TAP    4
`define MTLC_LC_EDGE_BIT  0
`define MTLC_LC_AUTO_BIT  1
`define MTLC_LC_SRC_BIT   2
`define MTLC_LC_EN_BIT    3
`define MTLC_T1_EN_BIT    2
`define MTLC_T1_STOP_BIT  3
`define MTLC_T2_PIN_BIT   3
`define MTLC_SYNC_BIT     0
`endif

// >>> rtl/mtlc_timer.v
`timescale 1ns/100ps
`include "mtlc_defines.vh"
module mtlc_timer (
  input  wire       CORE_CLK,
  input  wire       NRST,
  input  wire [3:0] TIMER3_CONTROL,
  input  wire       T3_SRC_A,
  input  wire       T3_SRC_B,
  input  wire       POWER_DOWN,
  input  wire       SKIP_T3,
  input  wire       INTACK_T3,
  output reg        TIMER3_IRQ_FLAG,
  output reg        WAKEUP,
  input  wire [3:0] TIMER_LC_CONTROL,
  input  wire       LC_WRITE,
  input  wire [3:0] LC_DATA,
  input  wire       SYS_SRC,
  output reg        LCD_CLK,
  input  wire [3:0] TIMER1_CONTROL,
  input  wire [3:0] TIMER2_CONTROL,
  input  wire [3:0] INT_CONTROL,
  input  wire       INT_VALID,
  input  wire       T1_UNDERFLOW,
  input  wire       T2_UNDERFLOW,
  input  wire       T1_SRC_INTERNAL,
  input  wire       T1_SRC_IS_PIN,
  input  wire       PWM_IN,
  input  wire       PWM_H_DONE,
  input  wire       SKIP_T1,
  input  wire       INTACK_T1,
  input  wire       SKIP_T2,
  input  wire       INTACK_T2,
  input  wire       PORTC_LATCH,
  input  wire       COUNTER_PIN_IN,
  output reg        COUNTER_PIN_OUT,
  output reg        COUNTER_PIN_OE,
  output reg        T1_COUNT_PULSE,
  output reg        T2_RUN,
  output reg        TIMER1_IRQ_FLAG,
  output reg        TIMER2_IRQ_FLAG
);
  reg  [15:0] t3_cnt_reg;
  reg  [15:0] t3_cnt_next;
  reg         t3_src_d_reg;
  reg  [3:0]  lc_cnt_reg;
  reg  [3:0]  lc_reload_reg;
  reg         lc_src_d_reg;
  reg         lc_armed_reg;
  reg         pin_d_reg;
  reg         sync_reg;
  reg         pin_valid_reg;
  reg         t2_run_reg;
  wire        t3_en   = TIMER3_CONTROL[`MTLC_T3_EN_BIT];
  wire        t3_src  = TIMER3_CONTROL[`MTLC_T3_SRC_BIT] ? T3_SRC_B : T3_SRC_A;
  wire        t3_tick = t3_en & t3_src & ~t3_src_d_reg;
  wire [1:0]  t3_sel  = TIMER3_CONTROL[`MTLC_T3_CNT_LSB+1:`MTLC_T3_CNT_LSB];
  reg         t3_uf;
  // Count values select a fixed wrap length; the timer wraps at zero of the chosen width.
  always @* begin
    t3_cnt_next = t3_cnt_reg - 16'h0001;
    case (t3_sel)
      2'h0: t3_uf = (t3_cnt_reg[8:0] == 9'h000);
      2'h1: t3_uf = (t3_cnt_reg[12:0] == 13'h0000);
      2'h2: t3_uf = (t3_cnt_reg[14:0] == 15'h0000);
      default: t3_uf = (t3_cnt_reg == 16'h0000);
    endcase
  end
  wire        t3_uf_ev = t3_tick & t3_uf;
  wire        lc_en    = TIMER_LC_CONTROL[`MTLC_LC_EN_BIT];
  wire        lc_src   = TIMER_LC_CONTROL[`MTLC_LC_SRC_BIT] ? SYS_SRC : t3_cnt_reg[`MTLC_T3_LC_TAP];
  wire        lc_rise  = lc_src & ~lc_src_d_reg;
  wire        lc_fall  = ~lc_src & lc_src_d_reg;
  wire        lc_uf    = lc_en & lc_armed_reg & lc_rise & (lc_cnt_reg == 4'h0);
  wire        edge_sel = TIMER_LC_CONTROL[`MTLC_LC_EDGE_BIT];
  wire        pin_edge = edge_sel ? (COUNTER_PIN_IN & ~pin_d_reg) : (~COUNTER_PIN_IN & pin_d_reg);
  wire        t1_en    = TIMER1_CONTROL[`MTLC_T1_EN_BIT];
  wire        sync_sel = INT_CONTROL[`MTLC_SYNC_BIT];
  wire        auto_stp = TIMER1_CONTROL[`MTLC_T1_STOP_BIT] & sync_sel;
  wire        src_raw  = T1_SRC_IS_PIN ? pin_edge : T1_SRC_INTERNAL;
  wire        pin_sel  = TIMER2_CONTROL[`MTLC_T2_PIN_BIT];
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      t3_cnt_reg      <= `MTLC_T3_INIT;
      t3_src_d_reg    <= 1'b0;
      TIMER3_IRQ_FLAG <= 1'b0;
      WAKEUP          <= 1'b0;
      lc_cnt_reg      <= 4'h0;
      lc_reload_reg   <= 4'h0;
      lc_src_d_reg    <= 1'b0;
      lc_armed_reg    <= 1'b0;
      LCD_CLK         <= 1'b0;
      pin_d_reg       <= 1'b0;
      sync_reg        <= 1'b0;
      // The pin output starts valid so that PWM shows when auto-control is never used.
      pin_valid_reg   <= 1'b1;
      t2_run_reg      <= 1'b0;
      T2_RUN          <= 1'b0;
      T1_COUNT_PULSE  <= 1'b0;
      COUNTER_PIN_OUT <= 1'b0;
      COUNTER_PIN_OE  <= 1'b0;
      TIMER1_IRQ_FLAG <= 1'b0;
      TIMER2_IRQ_FLAG <= 1'b0;
    end else begin
      t3_src_d_reg <= t3_src;
      if (!t3_en)
        t3_cnt_reg <= `MTLC_T3_INIT;
      else if (t3_tick)
        t3_cnt_reg <= t3_uf ? `MTLC_T3_INIT : t3_cnt_next;
      // Set wins over a clear landing in the same cycle.
      if (t3_uf_ev)
        TIMER3_IRQ_FLAG <= 1'b1;
      else if (SKIP_T3 | INTACK_T3)
        TIMER3_IRQ_FLAG <= 1'b0;
      WAKEUP <= t3_uf_ev & POWER_DOWN;
      lc_src_d_reg <= lc_src;
      if (LC_WRITE) begin
        lc_cnt_reg    <= LC_DATA;
        lc_reload_reg <= LC_DATA;
      end
      if (!lc_en)
        lc_armed_reg <= 1'b0;
      else if (lc_fall)
        lc_armed_reg <= 1'b1;
      if (lc_en & lc_armed_reg & lc_rise & !LC_WRITE)
        lc_cnt_reg <= (lc_cnt_reg == 4'h0) ? lc_reload_reg : lc_cnt_reg - 4'h1;
      if (lc_uf)
        LCD_CLK <= ~LCD_CLK;
      pin_d_reg <= COUNTER_PIN_IN;
      if (!sync_sel)
        sync_reg <= 1'b0;
      else if (INT_VALID)
        sync_reg <= 1'b1;
      else if (auto_stp & T1_UNDERFLOW)
        sync_reg <= 1'b0;
      T1_COUNT_PULSE <= t1_en & src_raw & (!sync_sel | sync_reg);
      if (!t1_en)
        pin_valid_reg <= pin_valid_reg;
      else if (TIMER_LC_CONTROL[`MTLC_LC_AUTO_BIT] & T1_UNDERFLOW)
        pin_valid_reg <= ~pin_valid_reg;
      // With PWM output selected, timer 2 keeps running after a stop request until its high interval ends or it underflows.
      if (TIMER2_CONTROL[1])
        t2_run_reg <= 1'b1;
      else if (!pin_sel | PWM_H_DONE | T2_UNDERFLOW)
        t2_run_reg <= 1'b0;
      T2_RUN <= TIMER2_CONTROL[1] | (t2_run_reg & pin_sel & !PWM_H_DONE & !T2_UNDERFLOW);
      if (T1_UNDERFLOW)
        TIMER1_IRQ_FLAG <= 1'b1;
      else if (SKIP_T1 | INTACK_T1)
        TIMER1_IRQ_FLAG <= 1'b0;
      if (T2_UNDERFLOW)
        TIMER2_IRQ_FLAG <= 1'b1;
      else if (SKIP_T2 | INTACK_T2)
        TIMER2_IRQ_FLAG <= 1'b0;
      // Turning auto-control off keeps the validity it had, so only the toggled state is used.
      COUNTER_PIN_OUT <= (pin_sel & pin_valid_reg) ? PWM_IN : PORTC_LATCH;
      COUNTER_PIN_OE  <= !T1_SRC_IS_PIN;
    end
  end
endmodule

// >>> tb/mtlc_timer_chk.sv
`timescale 1ns/100ps
module mtlc_timer_chk (
  input wire       CORE_CLK,
  input wire       NRST,
  input wire [3:0] TIMER3_CONTROL,
  input wire       POWER_DOWN,
  input wire       TIMER3_IRQ_FLAG,
  input wire       WAKEUP,
  input wire [3:0] TIMER_LC_CONTROL,
  input wire       LCD_CLK,
  input wire       T1_UNDERFLOW,
  input wire       T2_UNDERFLOW,
  input wire       T1_SRC_IS_PIN,
  input wire       SKIP_T1,
  input wire       INTACK_T1,
  input wire       COUNTER_PIN_OE,
  input wire       TIMER1_IRQ_FLAG,
  input wire       TIMER2_IRQ_FLAG
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  chk_t3_needs_en: assert property ($rose(TIMER3_IRQ_FLAG) |-> $past(TIMER3_CONTROL[2])) else $error("t3 flag off");
  chk_wake_pulse: assert property (WAKEUP |-> TIMER3_IRQ_FLAG && $past(POWER_DOWN) ##1 !WAKEUP) else $error("wake");
  chk_lc_idle: assert property (!TIMER_LC_CONTROL[3] [*2] |=> $stable(LCD_CLK)) else $error("lcd clk moved");
  chk_pin_hiz: assert property (T1_SRC_IS_PIN |=> !COUNTER_PIN_OE) else $error("pin driven");
  chk_t1_set: assert property (T1_UNDERFLOW |=> TIMER1_IRQ_FLAG) else $error("t1 flag not set");
  chk_t2_set: assert property (T2_UNDERFLOW |=> TIMER2_IRQ_FLAG) else $error("t2 flag not set");
  chk_t1_clear: assert property ((SKIP_T1 || INTACK_T1) && !T1_UNDERFLOW |=> !TIMER1_IRQ_FLAG) else $error("t1 clr");
  chk_t1_hold: assert property (TIMER1_IRQ_FLAG && !SKIP_T1 && !INTACK_T1 |=> TIMER1_IRQ_FLAG) else $error("t1 lost");
  cover property (WAKEUP);
  cover property ($rose(LCD_CLK));
  cover property ($fell(TIMER1_IRQ_FLAG));
endmodule
bind mtlc_timer mtlc_timer_chk u_chk (.*);

// >>> tb/mtlc_pin_model.sv
`timescale 1ns/100ps
module mtlc_pin_model (
  input  wire CORE_CLK,
  input  wire run,
  input  wire oe,
  input  wire dout,
  output wire din
);
  reg ext_reg = 1'b0;
  always @(posedge CORE_CLK) begin
    if (run) begin
      ext_reg <= ~ext_reg;
    end
  end
  // A floating line shows ext_reg while run is set, else the inverse of the last drive so a stale value cannot pass.
  assign din = oe ? dout : (run ? ext_reg : ~dout);
endmodule

// >>> tb/mtlc_timer_tb_top.sv
`timescale 1ns/100ps
module mtlc_timer_tb_top;
  logic [3:0] TIMER3_CONTROL=0, TIMER_LC_CONTROL=0, LC_DATA=0, TIMER1_CONTROL=0, TIMER2_CONTROL=0, INT_CONTROL=0;
  logic CORE_CLK=0, NRST=0, T3_SRC_A=0, T3_SRC_B=0, POWER_DOWN=0, SKIP_T3=0, INTACK_T3=0, LC_WRITE=0, SYS_SRC=0;
  logic INT_VALID=0, T1_UNDERFLOW=0, T2_UNDERFLOW=0, T1_SRC_INTERNAL=0, T1_SRC_IS_PIN=0, PWM_IN=0, PWM_H_DONE=0;
  logic SKIP_T1=0, INTACK_T1=0, SKIP_T2=0, INTACK_T2=0, PORTC_LATCH=0, ext_run=0;
  wire TIMER3_IRQ_FLAG, WAKEUP, LCD_CLK, COUNTER_PIN_IN, COUNTER_PIN_OUT, COUNTER_PIN_OE;
  wire T1_COUNT_PULSE, T2_RUN, TIMER1_IRQ_FLAG, TIMER2_IRQ_FLAG;
  int miscompares=0, n_tests=0, n_wake=0, n_lcd=0, n_t1=0;
  mtlc_timer dut (.*);
  mtlc_pin_model u_pin (.CORE_CLK(CORE_CLK), .run(ext_run), .oe(COUNTER_PIN_OE), .dout(COUNTER_PIN_OUT), .din(COUNTER_PIN_IN));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  always @(negedge CORE_CLK) begin
    n_wake += (WAKEUP === 1'b1);
    n_t1 += (T1_COUNT_PULSE === 1'b1);
  end
  always @(LCD_CLK) n_lcd++;
  task w(int n); repeat (n) @(posedge CORE_CLK); endtask
  task ck(string nm, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task edges(int n);
    repeat (n) begin
      w(1); {T3_SRC_A, T3_SRC_B, SYS_SRC} <= 3'h7;
      w(1); {T3_SRC_A, T3_SRC_B, SYS_SRC} <= 3'h0;
    end
    w(3); #1;
  endtask
  // Pulse bits: t1 uf, t2 uf, skip t1, ack t1, skip t2, ack t2, int valid, t1 src, skip t3, ack t3, lc write.
  task pl(logic [10:0] m);
    w(1); {T1_UNDERFLOW, T2_UNDERFLOW, SKIP_T1, INTACK_T1, SKIP_T2, INTACK_T2, INT_VALID, T1_SRC_INTERNAL,
           SKIP_T3, INTACK_T3, LC_WRITE} <= m;
    w(1); {T1_UNDERFLOW, T2_UNDERFLOW, SKIP_T1, INTACK_T1, SKIP_T2, INTACK_T2, INT_VALID, T1_SRC_INTERNAL,
           SKIP_T3, INTACK_T3, LC_WRITE} <= 11'h0;
    w(3); #1;
  endtask
  task run512(int pre);
    edges(511 - pre); ck("t3f", TIMER3_IRQ_FLAG, 0);
    edges(1); ck("t3f", TIMER3_IRQ_FLAG, 1);
  endtask
  task t_timer3;
    w(1); TIMER3_CONTROL <= 4'h8;
    w(1); TIMER3_CONTROL <= 4'hc;
    edges(1); POWER_DOWN <= 1'b1;
    run512(1); ck("wake", n_wake, 1);
    pl(11'h004); run512(0); ck("wake", n_wake, 2);
    pl(11'h002); edges(300); TIMER3_CONTROL <= 4'h8;
    edges(2); TIMER3_CONTROL <= 4'hc; run512(0);
  endtask
  task t_lc(logic [3:0] n);
    w(1); TIMER_LC_CONTROL <= 4'h4; LC_DATA <= n;
    pl(11'h001); TIMER_LC_CONTROL <= 4'hc;
    edges(1); n_lcd = 0;
    edges(2 * (n + 1)); ck("lcd", n_lcd, 2);
  endtask
  task t_flags;
    pl(11'h600); ck("t1f", TIMER1_IRQ_FLAG, 1); ck("t2f", TIMER2_IRQ_FLAG, 1);
    pl(11'h540); ck("t1f", TIMER1_IRQ_FLAG, 1); ck("t2f", TIMER2_IRQ_FLAG, 0);
    pl(11'h200); pl(11'h0a0); ck("t1f", TIMER1_IRQ_FLAG, 0); ck("t2f", TIMER2_IRQ_FLAG, 0);
  endtask
  task t_sync;
    w(1); TIMER1_CONTROL <= 4'hc; INT_CONTROL <= 4'h1; n_t1 = 0;
    pl(11'h008); ck("t1cnt", n_t1, 0);
    pl(11'h010); pl(11'h008); ck("t1cnt", n_t1, 1);
    pl(11'h400); pl(11'h008); ck("t1cnt", n_t1, 1);
  endtask
  task t_pin;
    w(1); T1_SRC_IS_PIN <= 1'b1; ext_run <= 1'b1; INT_CONTROL <= 4'h0; n_t1 = 0;
    w(5); #1 ck("oe", COUNTER_PIN_OE, 0);
    ck("pinfall", n_t1, 1);
    w(1); T1_SRC_IS_PIN <= 0; ext_run <= 0; PORTC_LATCH <= 0; TIMER2_CONTROL <= 4'h8; PWM_IN <= 1;
    w(3); #1 ck("pin", {COUNTER_PIN_OE, COUNTER_PIN_OUT}, 3);
    w(1); PWM_IN <= 0;
    w(3); #1 ck("pin", COUNTER_PIN_OUT, 0);
    w(1); TIMER2_CONTROL <= 4'ha;
    w(2); #1 ck("t2run", T2_RUN, 1);
    w(1); TIMER2_CONTROL <= 4'h8;
    w(3); #1 ck("t2run", T2_RUN, 1);
    w(1); PWM_H_DONE <= 1'b1;
    w(1); PWM_H_DONE <= 1'b0;
    w(2); #1 ck("t2run", T2_RUN, 0);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    w(16); NRST <= 1'b1;
    t_timer3; t_lc(4'h0); t_lc(4'h2); t_lc(4'hf); t_flags; t_sync; t_pin;
    test_done;
  end
  initial begin
    #300000; miscompares++; test_done;
  end
endmodule
